/* link_pwr_pkg.sv */
/*
  Shared constants for the isolated link mode and power controller: link modes,
  power states, rate codes, reset values and timing figures.
  Assumes a single 100 MHz clock; every cycle count is derived from that rate.
*/
`default_nettype none
package link_pwr_pkg;

  // Link mode, encoded in the order of the strap levels (lowest level first).
  typedef enum logic [1:0] {
    MODE_STD     = 2'b00,
    MODE_MONITOR = 2'b01,
    MODE_UNIDIR  = 2'b10,
    MODE_LOW_LAT = 2'b11
  } link_mode_e;

  // Power state, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_READY  = 3'b010,
    ST_ACTIVE = 3'b100
  } link_state_e;

  // Rate selection handed to the pulse coder.
  typedef enum logic [1:0] {
    RATE_1M = 2'b00,
    RATE_2M = 2'b01,
    RATE_4M = 2'b10
  } rate_e;

  localparam int CLOCK_MHZ = 100;

  // Timing figures in their own units; plain defaults.
  localparam int WAKE_DWELL_NS = 240;
  localparam int READY_SETTLE_US = 10;
  localparam int IDLE_TIMEOUT_US = 5000;

  // A least time rounds up, so the dwell count is a ceiling.
  localparam int WAKE_DWELL_CYCLES = (WAKE_DWELL_NS * CLOCK_MHZ + 999) / 1000;
  localparam int READY_SETTLE_CYCLES = READY_SETTLE_US * CLOCK_MHZ;
  localparam int IDLE_TIMEOUT_CYCLES = IDLE_TIMEOUT_US * CLOCK_MHZ;

  // Reset values of the captured straps.
  localparam link_mode_e MODE_RESET = MODE_MONITOR;
  localparam logic [1:0] PHASE_POL_RESET = 2'b11;

  // Field positions inside the phase and polarity strap.
  localparam int PHA_BIT = 0;
  localparam int POL_BIT = 1;

  // Levels of the SPI outputs while the peripheral side is idle.
  localparam logic IDLE_CS_N = 1'b1;
  localparam logic IDLE_PICO = 1'b1;

  // Width of the group of pin inputs that pass the synchroniser.
  localparam int PIN_SYNC_W = 9;

endpackage : link_pwr_pkg
`default_nettype wire

/* pin_sync.sv */
/*
  Two-flop synchroniser for a group of level inputs.
  Assumes each bit is a slow level; the bits are not coherent as a word.
*/
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_r;

  // The first stage feeds only the second stage, to keep metastability contained.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : pin_sync
`default_nettype wire

/* cycle_timer.sv */
/*
  Restartable down counter that reports expiry after CYCLES quiet cycles.
  Assumes the caller restarts it on every event that must postpone expiry.
*/
`default_nettype none
module cycle_timer #(
  parameter int CYCLES = 1
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic restart,
  output logic expired
);

  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LOAD = W'(CYCLES);

  logic [W-1:0] count_r;

  // Reset loads the full count so nothing reads as expired straight out of reset.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= LOAD;
    end else if (restart) begin
      count_r <= LOAD;
    end else if (count_r != '0) begin
      count_r <= count_r - W'(1);
    end
  end

  assign expired = (count_r == '0);

endmodule : cycle_timer
`default_nettype wire

/* link_mode_power_ctrl.sv */
/*
  Mode and power-state control of one isolated serial-link transceiver:
  idle, ready and active states, wake-up sources, strap capture, per-mode
  enables for the pulse coder, the awake pin and the monitoring alert.
  Assumes the analog front end delivers wake detection, supply presence and
  strap levels as digital levels, and that the pulse coder on this clock
  reports link activity, decoded chip-select events and heartbeat results.
*/
// What the document requires of this block
// [RULE1] Monitor mode as controller behaves like standard bidirectional mode.
// [RULE2] Monitor mode as peripheral receives and decodes at 2 Mbps, never transmits.
// [RULE3] Monitor mode as peripheral enables low-power monitoring and listens for heartbeats.
// [RULE4] Unidirectional controller transmits only, up to 4 Mbps, never receives.
// [RULE5] Unidirectional peripheral receives up to 4 Mbps, never transmits.
// [RULE6] Reduced-latency peripheral returns bits from the latching clock edge.
// [RULE7] Reduced-latency peripheral sends no bit after the long chip-select-low pulse.
// [RULE8] Idle powers down all but wake detection.
// [RULE9] Ready has everything enabled with no pulses on the link.
// [RULE10] Active while data flows, back to ready when it stops.
// [RULE11] Without interface supply force peripheral and keep the captured straps.
// [RULE12] Peripheral idles after the timeout, holding chip-select, PICO high, SCK at polarity.
// [RULE13] Wake on a dwelled detector signal, then settle within the ready time.
// [RULE14] Controller also wakes when chip-select goes low.
// [RULE15] Chip-select rising after wake sends the long pulse that wakes the remote side.
// [RULE16] Controller stays awake while chip-select is low, idles after the timeout.
// [RULE17] Awake pin high in ready or active, low in idle, no alerts on it.
// [RULE18] Peripheral outside monitor mode wakes on a held awake pin and sends wake pulse.
// [RULE19] Peripheral never produces positive link pulses.
// [RULE20] Multidrop peripherals must be individually addressable; this block has no address decoding.
// [RULE21] Unaddressed multidrop peripherals keep their data output high; here spi_pico_o follows dec_pico whenever awake.
// [RULE22] Controller select high means controller, low means peripheral.
// [RULE23] Mode strap is sampled only on the idle to ready transition.
// [RULE24] Before the first sample the mode is bidirectional with monitor support.
// [RULE25] Idle and settle times are restartable cycle counters.
// [RULE26] Front-end levels arrive as synchronised digital inputs.
`default_nettype none
module link_mode_power_ctrl
  import link_pwr_pkg::*;
#(
  parameter int IDLE_CYCLES = IDLE_TIMEOUT_CYCLES
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic controller_select,
  input wire logic interface_supply,
  input wire logic wake_detect,
  input wire logic host_cs_n,
  input wire logic [1:0] link_mode_strap,
  input wire logic [1:0] phase_polarity_strap,
  input wire logic awake_i,
  output logic awake_o,
  output logic awake_oe,
  input wire logic link_activity,
  input wire logic rx_cs_low_event,
  input wire logic rx_bit_event,
  input wire logic dec_cs_n,
  input wire logic dec_pico,
  input wire logic dec_sck,
  input wire logic hb_pass,
  input wire logic hb_fail,
  input wire logic hb_timeout,
  output logic circuit_power_en,
  output logic bias_ready,
  output logic tx_enable,
  output logic tx_pos_allow,
  output logic rx_enable,
  output logic response_enable,
  output logic response_on_latch_edge,
  output link_pwr_pkg::rate_e link_rate,
  output link_pwr_pkg::link_mode_e link_mode,
  output logic controller_mode,
  output logic [1:0] phase_polarity,
  output logic spi_cs_n_o,
  output logic spi_pico_o,
  output logic spi_sck_o,
  output logic spi_oe,
  output logic long_pulse_req,
  output logic wake_pulse_req,
  output logic low_power_monitoring,
  output logic timeout_alert
);

  logic ctrl_s, supply_s, wake_s, cs_n_s, awake_s;
  logic [1:0] mode_strap_s, pp_strap_s;
  logic is_ctrl, supply_d_r, cs_n_d_r, lpm_d_r;
  logic dwell_exp, awake_exp, settle_exp, idle_exp;
  logic dwell_hit, awake_hit, cs_wake, wake_req, awake_input_mode;
  logic tx_allowed, rx_allowed, resp_block_r, is_idle;
  link_state_e state_r, state_nxt;
  link_mode_e link_mode_r;
  logic [1:0] phase_pol_r;

  // Every front-end and pin level is synchronised before use. [RULE26]
  pin_sync #(
    .WIDTH(PIN_SYNC_W)
  ) u_sync (
    .clock(clock),
    .rst_n(rst_n),
    .d({controller_select, interface_supply, wake_detect, host_cs_n, awake_i,
        link_mode_strap, phase_polarity_strap}),
    .q({ctrl_s, supply_s, wake_s, cs_n_s, awake_s, mode_strap_s, pp_strap_s})
  );

  // Role and wake sources; a missing interface supply forces the peripheral role.
  assign is_ctrl = ctrl_s & supply_s; // [RULE11] [RULE22]
  assign is_idle = (state_r == ST_IDLE);
  assign awake_input_mode = !is_ctrl && (link_mode_e'(mode_strap_s) != MODE_MONITOR);
  assign dwell_hit = wake_s & dwell_exp; // [RULE13]
  assign cs_wake = is_ctrl & !cs_n_s; // [RULE14]
  assign awake_hit = awake_input_mode & awake_s & awake_exp; // [RULE18]
  assign wake_req = is_idle & (dwell_hit | cs_wake | awake_hit);

  // The detector level must stay up for the dwell time before it counts.
  cycle_timer #(
    .CYCLES(WAKE_DWELL_CYCLES)
  ) u_dwell (
    .clock(clock),
    .rst_n(rst_n),
    .restart(!wake_s),
    .expired(dwell_exp)
  );

  // The externally driven awake pin must stay high for the settle time. [RULE18]
  // Held loaded while awake: our own high drive is still in the synchroniser just
  // after idling and would otherwise wake the block again at once.
  cycle_timer #(
    .CYCLES(READY_SETTLE_CYCLES)
  ) u_awake_hold (
    .clock(clock),
    .rst_n(rst_n),
    .restart(!awake_s || !is_idle),
    .expired(awake_exp)
  );

  // Bias settle time runs from the wake event; idle keeps it loaded. [RULE25]
  cycle_timer #(
    .CYCLES(READY_SETTLE_CYCLES)
  ) u_settle (
    .clock(clock),
    .rst_n(rst_n),
    .restart(is_idle),
    .expired(settle_exp)
  );

  // Link activity, or a controller chip-select held low, postpones idling. [RULE25] [RULE16]
  cycle_timer #(
    .CYCLES(IDLE_CYCLES)
  ) u_idle (
    .clock(clock),
    .rst_n(rst_n),
    .restart(is_idle | link_activity | cs_wake),
    .expired(idle_exp)
  );

  // Power state transitions.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (wake_req) begin
          state_nxt = ST_READY; // [RULE13] [RULE14] [RULE18]
        end
      end
      ST_READY: begin
        if (link_activity) begin
          state_nxt = ST_ACTIVE; // [RULE10]
        end else if (idle_exp && !cs_wake) begin
          // A chip-select low that meets an expiring timer still keeps us awake.
          state_nxt = ST_IDLE; // [RULE12] [RULE16]
        end
      end
      ST_ACTIVE: begin
        if (!link_activity) begin
          state_nxt = ST_READY; // [RULE10]
        end
      end
    endcase
  end

  // State register.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // The mode strap is taken only when leaving idle with the supply present,
  // so a strap change mid-session waits for the next wake. [RULE23] [RULE24] [RULE11]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_mode_r <= MODE_RESET;
    end else if (wake_req && supply_s) begin
      link_mode_r <= link_mode_e'(mode_strap_s);
    end
  end

  // Phase and polarity follow a supply power-up while awake, or the wake itself. [RULE11]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      phase_pol_r <= PHASE_POL_RESET;
    end else if (supply_s && (wake_req || (!supply_d_r && !is_idle))) begin
      phase_pol_r <= pp_strap_s;
    end
  end

  // Edge history of synchronised levels.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      supply_d_r <= 1'b0;
      cs_n_d_r <= 1'b1;
      lpm_d_r <= 1'b0;
    end else begin
      supply_d_r <= supply_s;
      cs_n_d_r <= cs_n_s;
      lpm_d_r <= low_power_monitoring;
    end
  end

  // Direction permissions per mode; monitor mode as controller equals standard.
  always_comb begin
    tx_allowed = 1'b1;
    rx_allowed = 1'b1;
    unique case (link_mode_r)
      MODE_STD, MODE_LOW_LAT: begin
        tx_allowed = 1'b1;
      end
      MODE_MONITOR: begin
        tx_allowed = is_ctrl; // [RULE1] [RULE2]
      end
      MODE_UNIDIR: begin
        tx_allowed = is_ctrl; // [RULE4] [RULE5]
        rx_allowed = !is_ctrl; // [RULE4] [RULE5]
      end
    endcase
  end

  // The reduced-latency peripheral holds back its reply after a chip-select-low
  // pulse until the next data bit arrives; a new pulse wins over that bit. [RULE7]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      resp_block_r <= 1'b0;
    end else if (rx_cs_low_event && link_mode_r == MODE_LOW_LAT && !is_ctrl) begin
      resp_block_r <= 1'b1;
    end else if (rx_bit_event || is_idle) begin
      resp_block_r <= 1'b0;
    end
  end

  // Coder enables. Idle drops all but response_on_latch_edge; the wake detector sits outside.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      circuit_power_en <= 1'b0;
      bias_ready <= 1'b0;
      tx_enable <= 1'b0;
      tx_pos_allow <= 1'b0;
      rx_enable <= 1'b0;
      response_enable <= 1'b0;
      response_on_latch_edge <= 1'b0;
    end else begin
      circuit_power_en <= !is_idle; // [RULE8] [RULE9]
      bias_ready <= !is_idle && settle_exp; // [RULE13]
      tx_enable <= !is_idle && tx_allowed; // [RULE9] [RULE2] [RULE5]
      tx_pos_allow <= !is_idle && tx_allowed && is_ctrl; // [RULE19]
      rx_enable <= !is_idle && rx_allowed; // [RULE2] [RULE4]
      response_enable <= !is_idle && !is_ctrl && tx_allowed && !resp_block_r; // [RULE7]
      response_on_latch_edge <= !is_ctrl && link_mode_r == MODE_LOW_LAT; // [RULE6]
    end
  end

  // Rate and mode reporting; the controller may run 2 Mbps in standard mode.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_rate <= RATE_1M;
      link_mode <= MODE_RESET;
      controller_mode <= 1'b0;
      phase_polarity <= PHASE_POL_RESET;
    end else begin
      unique case (link_mode_r)
        MODE_UNIDIR: link_rate <= RATE_4M; // [RULE4] [RULE5]
        MODE_LOW_LAT: link_rate <= RATE_2M; // [RULE6]
        MODE_MONITOR: link_rate <= is_ctrl ? RATE_2M : RATE_2M; // [RULE2]
        MODE_STD: link_rate <= is_ctrl ? RATE_2M : RATE_1M;
      endcase
      link_mode <= link_mode_r;
      controller_mode <= is_ctrl;
      phase_polarity <= phase_pol_r;
    end
  end

  // Peripheral SPI pins: idle levels in idle, decoded levels otherwise.
  // In controller mode these pins are inputs, so the enable drops.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      spi_cs_n_o <= IDLE_CS_N;
      spi_pico_o <= IDLE_PICO;
      spi_sck_o <= PHASE_POL_RESET[POL_BIT];
      spi_oe <= 1'b0;
    end else begin
      spi_oe <= !is_ctrl;
      if (is_idle) begin
        spi_cs_n_o <= IDLE_CS_N; // [RULE12]
        spi_pico_o <= IDLE_PICO; // [RULE12]
        spi_sck_o <= phase_pol_r[POL_BIT]; // [RULE12]
      end else begin
        spi_cs_n_o <= dec_cs_n;
        spi_pico_o <= dec_pico;
        spi_sck_o <= dec_sck;
      end
    end
  end

  // Wake pulses toward the far end, each one cycle long.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      long_pulse_req <= 1'b0;
      wake_pulse_req <= 1'b0;
    end else begin
      long_pulse_req <= is_ctrl && !is_idle && cs_n_s && !cs_n_d_r && tx_allowed; // [RULE15]
      wake_pulse_req <= is_idle && awake_hit; // [RULE18]
    end
  end

  // Awake pin follows the next state so it lines up with the state register.
  // It releases the pin in idle when the far side may drive it as a wake input.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      awake_o <= 1'b0;
      awake_oe <= 1'b1;
    end else begin
      awake_o <= (state_nxt != ST_IDLE); // [RULE17]
      awake_oe <= !((state_nxt == ST_IDLE) && awake_input_mode);
    end
  end

  // Monitoring alert: raised on activation and on a failed or missing heartbeat,
  // cleared by a pass; a raising event in the same cycle as a pass wins. [RULE3]
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      low_power_monitoring <= 1'b0;
      timeout_alert <= 1'b0;
    end else begin
      low_power_monitoring <= !is_ctrl && link_mode_r == MODE_MONITOR; // [RULE3]
      if (!low_power_monitoring) begin
        timeout_alert <= 1'b0;
      end else if (!lpm_d_r || hb_fail || hb_timeout) begin
        timeout_alert <= 1'b1;
      end else if (hb_pass) begin
        timeout_alert <= 1'b0;
      end
    end
  end

  AST_PERIPH_NO_POS: assert property (@(posedge clock) disable iff (!rst_n) // [RULE19]
    !is_ctrl |=> !tx_pos_allow)
    else $error("Peripheral allowed positive pulses.");

  AST_MON_PERIPH: assert property (@(posedge clock) disable iff (!rst_n) // [RULE2]
    (!is_ctrl && link_mode_r == MODE_MONITOR && !is_idle) |=> (!tx_enable && rx_enable))
    else $error("Monitor peripheral direction wrong.");

  AST_UNI_CTRL: assert property (@(posedge clock) disable iff (!rst_n) // [RULE4]
    (is_ctrl && link_mode_r == MODE_UNIDIR && !is_idle) |=> (tx_enable && !rx_enable
      && link_rate == RATE_4M))
    else $error("Unidirectional controller direction wrong.");

  AST_UNI_PERIPH: assert property (@(posedge clock) disable iff (!rst_n) // [RULE5]
    (!is_ctrl && link_mode_r == MODE_UNIDIR && !is_idle) |=> (!tx_enable && rx_enable))
    else $error("Unidirectional peripheral direction wrong.");

  AST_IDLE_PINS: assert property (@(posedge clock) disable iff (!rst_n) // [RULE12]
    (is_idle && $past(is_idle)) |-> (spi_cs_n_o && spi_pico_o
      && spi_sck_o == phase_pol_r[POL_BIT] && !circuit_power_en))
    else $error("Idle SPI levels wrong.");

  AST_MODE_HOLD: assert property (@(posedge clock) disable iff (!rst_n) // [RULE23]
    (!is_idle && !wake_req) |=> $stable(link_mode_r))
    else $error("Mode changed outside the wake transition.");

  AST_CTRL_STAY: assert property (@(posedge clock) disable iff (!rst_n) // [RULE16]
    (cs_wake && !is_idle) |=> !is_idle)
    else $error("Controller idled with chip-select low.");

  AST_LONG_PULSE: assert property (@(posedge clock) disable iff (!rst_n) // [RULE15]
    (is_ctrl && !is_idle && tx_allowed && $rose(cs_n_s)) |=> long_pulse_req)
    else $error("Chip-select rise gave no long pulse.");

  AST_AWAKE_PIN: assert property (@(posedge clock) disable iff (!rst_n) // [RULE17]
    $fell(is_idle) |-> awake_o ##0 (!is_idle)[*2])
    else $error("Awake pin does not follow the wake.");

  AST_LPM: assert property (@(posedge clock) disable iff (!rst_n) // [RULE3]
    $rose(low_power_monitoring) |=> timeout_alert)
    else $error("Alert not raised on monitoring start.");

endmodule : link_mode_power_ctrl
`default_nettype wire

/* link_far_model.sv */
/*
  Behavioural far side of the mode controller: pulse coder, decoded SPI
  levels and heartbeat logic. Assumes the bench calls its tasks at a falling
  clock edge, and that one addressable peripheral sits on the cable.
*/
`default_nettype none
module link_far_model (
  input wire logic clock,
  output logic link_activity,
  output logic rx_cs_low_event,
  output logic rx_bit_event,
  output logic dec_cs_n,
  output logic dec_pico,
  output logic dec_sck,
  output logic hb_pass,
  output logic hb_fail,
  output logic hb_timeout
);
  timeunit 1ns;
  timeprecision 1ps;

  // A quiet cable keeps the peripheral deselected with its data line high.
  initial begin
    {link_activity, rx_cs_low_event, rx_bit_event} = 3'h0;
    {hb_pass, hb_fail, hb_timeout} = 3'h0;
    dec_cs_n = 1'b1;
    dec_pico = 1'b1;
    dec_sck = 1'b1;
  end

  // A burst of traffic: one bit every four cycles while the clock toggles.
  task automatic burst(input int n);
    link_activity = 1'b1;
    dec_cs_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      @(negedge clock);
      dec_sck = ~dec_sck;
      rx_bit_event = (i % 4 == 3);
    end
    @(negedge clock);
    {link_activity, rx_bit_event, dec_cs_n, dec_sck} = 4'h3;
  endtask : burst

  // One-cycle events; the mask picks cs-low, bit, pass, fail, timeout.
  task automatic pulse(input logic [4:0] m);
    {rx_cs_low_event, rx_bit_event, hb_pass, hb_fail, hb_timeout} = m;
    @(negedge clock);
    {rx_cs_low_event, rx_bit_event, hb_pass, hb_fail, hb_timeout} = 5'h00;
  endtask : pulse
endmodule : link_far_model
`default_nettype wire

/* link_mode_power_ctrl_tb.sv */
/*
  Self-checking bench for the link mode and power controller.
  Assumes a 100 MHz clock and a shortened idle timeout of 50 cycles.
*/
`default_nettype none
module link_mode_power_ctrl_tb;
  import link_pwr_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int IDLE_CYC = 50;
  logic clock, rst_n, controller_select, interface_supply, wake_detect, host_cs_n;
  logic ext_awake, awake_o, awake_oe, link_activity, rx_cs_low_event, rx_bit_event;
  logic dec_cs_n, dec_pico, dec_sck, hb_pass, hb_fail, hb_timeout, circuit_power_en;
  logic bias_ready, tx_enable, tx_pos_allow, rx_enable, response_enable;
  logic response_on_latch_edge, controller_mode, spi_cs_n_o, spi_pico_o, spi_sck_o;
  logic spi_oe, long_pulse_req, wake_pulse_req, low_power_monitoring, timeout_alert;
  logic [1:0] link_mode_strap, phase_polarity_strap, phase_polarity;
  rate_e link_rate;
  link_mode_e link_mode;
  int fail_count, num_checks;
  // The awake pin is driven by the block while enabled, else by the bench.
  wire logic awake_pin = awake_oe ? awake_o : ext_awake;

  link_mode_power_ctrl #(.IDLE_CYCLES(IDLE_CYC)) dut (
    .clock, .rst_n, .controller_select, .interface_supply, .wake_detect, .host_cs_n,
    .link_mode_strap, .phase_polarity_strap, .awake_i(awake_pin), .awake_o, .awake_oe,
    .link_activity, .rx_cs_low_event, .rx_bit_event, .dec_cs_n, .dec_pico, .dec_sck,
    .hb_pass, .hb_fail, .hb_timeout, .circuit_power_en, .bias_ready, .tx_enable,
    .tx_pos_allow, .rx_enable, .response_enable, .response_on_latch_edge, .link_rate,
    .link_mode, .controller_mode, .phase_polarity, .spi_cs_n_o, .spi_pico_o,
    .spi_sck_o, .spi_oe, .long_pulse_req, .wake_pulse_req, .low_power_monitoring,
    .timeout_alert);

  link_far_model far (
    .clock, .link_activity, .rx_cs_low_event, .rx_bit_event, .dec_cs_n, .dec_pico,
    .dec_sck, .hb_pass, .hb_fail, .hb_timeout);

  // Free-running clock.
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : cyc

  // Bounded wait, since a hung state machine must not stall the run.
  task automatic wait_awake(input logic v, input int lim);
    int i;
    i = 0;
    while (awake_o !== v && i < lim) begin
      @(negedge clock);
      i++;
    end
    chk(awake_o, v);
  endtask : wait_awake

  task automatic wake_per(input logic [1:0] m);
    link_mode_strap = m;
    wake_detect = 1'b1;
    cyc(40);
    wake_detect = 1'b0;
    wait_awake(1'b1, 10);
    cyc(3);
  endtask : wake_per

  task automatic idle_per();
    wait_awake(1'b0, 2 * IDLE_CYC);
    cyc(3);
    chk({spi_cs_n_o, spi_pico_o, spi_sck_o, circuit_power_en}, 4'hc);
  endtask : idle_per

  task automatic t_reset();
    chk(awake_o, 1'b0);
    chk(link_mode, MODE_MONITOR);
    chk({phase_polarity, spi_cs_n_o, spi_pico_o}, 4'hf);
  endtask : t_reset

  task automatic t_ctrl_wake();
    controller_select = 1'b1;
    host_cs_n = 1'b0;
    wait_awake(1'b1, 10);
    cyc(3);
    chk({controller_mode, circuit_power_en, tx_pos_allow}, 3'h7);
    chk({link_mode, phase_polarity}, {MODE_STD, 2'b01});
    link_mode_strap = 2'b10;
    cyc(1100);
    chk({awake_o, bias_ready, link_mode}, {2'b11, MODE_STD});
  endtask : t_ctrl_wake

  task automatic t_supply();
    interface_supply = 1'b0;
    phase_polarity_strap = 2'b10;
    cyc(5);
    chk({controller_mode, phase_polarity, link_mode}, {3'b001, MODE_STD});
    phase_polarity_strap = 2'b01;
    interface_supply = 1'b1;
    cyc(5);
    chk(controller_mode, 1'b1);
  endtask : t_supply

  task automatic t_ctrl_idle();
    int n;
    n = 0;
    host_cs_n = 1'b1;
    repeat (10) begin
      @(negedge clock);
      if (long_pulse_req === 1'b1) n++;
    end
    chk(n[7:0], 8'h01);
    cyc(IDLE_CYC - 20);
    chk(awake_o, 1'b1);
    wait_awake(1'b0, 40);
    cyc(2);
    chk(circuit_power_en, 1'b0);
    host_cs_n = 1'b0;
    wait_awake(1'b1, 10);
    cyc(3);
    chk({link_mode, tx_enable, rx_enable, link_rate}, {MODE_UNIDIR, 2'b10, RATE_4M});
    host_cs_n = 1'b1;
    wait_awake(1'b0, 100);
  endtask : t_ctrl_idle

  task automatic t_per_std();
    controller_select = 1'b0;
    wake_detect = 1'b1;
    cyc(12);
    wake_detect = 1'b0;
    cyc(20);
    chk(awake_o, 1'b0);
    wake_per(2'b00);
    chk({controller_mode, spi_oe, tx_pos_allow, link_rate}, {3'b010, RATE_1M});
    far.burst(2 * IDLE_CYC);
    chk(awake_o, 1'b1);
    idle_per();
    wake_per(2'b10);
    chk({tx_enable, rx_enable, link_rate}, {2'b01, RATE_4M});
    idle_per();
  endtask : t_per_std

  task automatic t_per_lowlat();
    wake_per(2'b11);
    chk({response_on_latch_edge, response_enable, link_rate}, {2'b11, RATE_2M});
    far.pulse(5'h10);
    cyc(2);
    chk(response_enable, 1'b0);
    far.pulse(5'h08);
    cyc(2);
    chk(response_enable, 1'b1);
    idle_per();
  endtask : t_per_lowlat

  task automatic t_awake_pin();
    int n;
    link_mode_strap = 2'b00;
    cyc(3);
    chk(awake_oe, 1'b0);
    ext_awake = 1'b1;
    for (n = 0; n < 1100 && wake_pulse_req !== 1'b1; n++) @(negedge clock);
    chk({n >= 1000, wake_pulse_req}, 2'b11);
    ext_awake = 1'b0;
    cyc(3);
    chk({awake_oe, awake_o}, 2'b11);
    idle_per();
  endtask : t_awake_pin

  task automatic t_monitor();
    wake_per(2'b01);
    chk({low_power_monitoring, timeout_alert, tx_enable, response_enable, rx_enable,
        link_rate}, {5'b11001, RATE_2M});
    chk(awake_o, 1'b1);
    for (int i = 0; i < 4; i++) begin
      far.pulse(i[0] ? (i == 1 ? 5'h02 : 5'h01) : 5'h04);
      cyc(2);
      chk(timeout_alert, i[0]);
    end
    // A fail arriving with a pass must still raise the alert.
    far.pulse(5'h04);
    cyc(2);
    far.pulse(5'h06);
    cyc(2);
    chk(timeout_alert, 1'b1);
    controller_select = 1'b1;
    cyc(5);
    chk({low_power_monitoring, timeout_alert, tx_enable, rx_enable, link_rate},
        {4'b0011, RATE_2M});
  endtask : t_monitor

  task automatic print_verdict();
    $display("checks=%0d errors=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict

  // Main sequence; every input has a value at time zero.
  initial begin
    {rst_n, controller_select, wake_detect, host_cs_n, ext_awake} = 5'h02;
    interface_supply = 1'b1;
    link_mode_strap = 2'b00;
    phase_polarity_strap = 2'b01;
    fail_count = 0;
    num_checks = 0;
    cyc(8);
    rst_n = 1'b1;
    cyc(2);
    t_reset();
    t_ctrl_wake();
    t_supply();
    t_ctrl_idle();
    t_per_std();
    t_per_lowlat();
    t_awake_pin();
    t_monitor();
    print_verdict();
  end

  // Watchdog set well beyond the few thousand cycles the tests need.
  initial begin
    #200_000;
    fail_count++;
    print_verdict();
  end
endmodule : link_mode_power_ctrl_tb
`default_nettype wire
